// ===== design/alu_defines.vh
// constants for the multiply / zero-extend / or execution slice
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH
// register port offsets
`define REG_FLAGS 8'h00
`define REG_STATUS 8'h04
// flag bit positions inside the flag register
`define FLG_CY 4
`define FLG_AC 3
`define FLG_OV 2
`define FLG_N 1
`define FLG_Z 0
`define FLAGS_RST 5'h00
// status bit positions
`define STS_BUSY 0
`define STS_ILLEGAL 1
// escape prefix byte
`define ESC_BYTE 8'hA5
// opcodes
`define OP_NOP 8'h00
`define OP_ZEXT 8'h0A
`define OP_MUL_B 8'hAC
`define OP_MUL_W 8'hAD
`define OP_MUL_AB 8'hA4
`define OP_OR_D_A 8'h42
`define OP_OR_D_I 8'h43
`define OP_OR_A_I 8'h44
`define OP_OR_A_D 8'h45
`define OP_OR_RR 8'h4C
`define OP_OR_WW 8'h4D
`define OP_OR_EXT 8'h4E
`define OP_ORC_B 8'h72
`define OP_ORC_NB 8'hA0
`define OP_ORC_EXT 8'hA9
// execution state counts without escape and port additions
`define ST_ONE 4'd1
`define ST_TWO 4'd2
`define ST_THREE 4'd3
`define ST_MUL_B 4'd5
`define ST_MUL_W 4'd11
`define ST_MUL_AB 4'd5
`define ST_PORT_OR_D_A 4'd2
`define ST_PORT_ONE 4'd1
// write target kinds
`define KIND_REG 2'd0
`define KIND_ACC 2'd1
`define KIND_B 2'd2
`define KIND_DIR 2'd3
`endif

// ===== design/or_mul_alu.v
// execution slice: zero-extend move, unsigned multiply, no-op, logical or
//
// Added by the designer: the strobed register port and the register addresses.
`include "alu_defines.vh"

module or_mul_alu (
   input wire clk,
   input wire rst,
   input wire issue,
   output wire ready,
   input wire src_mode,
   input wire esc_seen,
   input wire [7:0] op_byte0,
   input wire [7:0] op_byte1,
   input wire [7:0] op_byte2,
   input wire [15:0] opnd_a,
   input wire [15:0] opnd_b,
   input wire dir_is_port,
   input wire [7:0] latch_val,
   input wire src_bit,
   output reg done_r,
   output reg illegal_pulse_r,
   output reg [2:0] len_r,
   output reg wr0_en_r,
   output reg [1:0] wr0_kind_r,
   output reg [4:0] wr0_idx_r,
   output reg wr0_word_r,
   output reg [15:0] wr0_data_r,
   output reg wr1_en_r,
   output reg [1:0] wr1_kind_r,
   output reg [4:0] wr1_idx_r,
   output reg wr1_word_r,
   output reg [15:0] wr1_data_r,
   output wire [4:0] flags,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r
);

   // form classes for escape checking
   localparam FORM_PLAIN = 2'd0; // same code in both modes
   localparam FORM_EXT = 2'd1; // escape in binary mode only
   localparam FORM_ORIG = 2'd2; // escape in source mode only

   reg busy_r; // an instruction is executing
   reg [3:0] cnt_r; // state periods still to run
   reg illegal_r; // sticky: an unknown code was issued
   reg [4:0] flags_r; // carry, aux, overflow, negative, zero

   // pending results, copied to the outputs on completion
   reg p_illegal_r;
   reg [2:0] p_len_r;
   reg p_w0_en_r;
   reg [1:0] p_w0_kind_r;
   reg [4:0] p_w0_idx_r;
   reg p_w0_word_r;
   reg [15:0] p_w0_data_r;
   reg p_w1_en_r;
   reg [1:0] p_w1_kind_r;
   reg [4:0] p_w1_idx_r;
   reg p_w1_word_r;
   reg [15:0] p_w1_data_r;
   reg [4:0] p_fmask_r; // which flags the instruction changes
   reg [4:0] p_fval_r;
   reg p_bitor_r; // carry is or'ed rather than loaded
   reg p_bitval_r;

   // decoded fields of the current issue
   reg [1:0] d_form;
   reg d_ok;
   reg [3:0] d_states;
   reg [2:0] d_len;
   reg d_w0_en;
   reg [1:0] d_w0_kind;
   reg [4:0] d_w0_idx;
   reg d_w0_word;
   reg [15:0] d_w0_data;
   reg d_w1_en;
   reg [1:0] d_w1_kind;
   reg [4:0] d_w1_idx;
   reg d_w1_word;
   reg [15:0] d_w1_data;
   reg [4:0] d_fmask;
   reg [4:0] d_fval;
   reg d_bitor;
   reg d_bitval;
   reg [7:0] or_b; // byte or result
   reg [15:0] or_w; // word or result
   reg [7:0] dest_b; // destination byte as read for the or

   wire [15:0] prod8; // byte product
   wire [31:0] prod16; // word product
   wire esc_ok; // prefix matches the form and mode
   wire esc_add; // extra state and byte for the escape
   wire take; // issue accepted this cycle
   wire last; // final state period of the current one
   wire [3:0] total; // state periods including the escape

   // operands widened first so the product keeps its upper half
   assign prod8 = {8'h00, opnd_a[7:0]} * {8'h00, opnd_b[7:0]};
   assign prod16 = {16'h0000, opnd_a} * {16'h0000, opnd_b};
   assign last = busy_r && (cnt_r == 4'd0);
   // a new issue may overlap the last period of the previous one
   assign ready = ~busy_r | last;
   assign take = issue & ready;
   assign flags = flags_r;

   // escape rules: extended forms need the prefix only in binary mode,
   // original forms need it only in source mode
   assign esc_ok = (d_form == FORM_PLAIN) ? ~esc_seen :
                   (d_form == FORM_EXT) ? (esc_seen == ~src_mode) :
                   (esc_seen == src_mode);
   assign esc_add = esc_seen & (d_form != FORM_PLAIN);
   assign total = d_states + {3'b000, esc_add};

   // instruction decode and result formation
   always @*
   begin
      d_form = FORM_PLAIN;
      d_ok = 1'b1;
      d_states = `ST_ONE;
      d_len = 3'd1;
      d_w0_en = 1'b0;
      d_w0_kind = `KIND_REG;
      d_w0_idx = 5'h00;
      d_w0_word = 1'b0;
      d_w0_data = 16'h0000;
      d_w1_en = 1'b0;
      d_w1_kind = `KIND_REG;
      d_w1_idx = 5'h00;
      d_w1_word = 1'b0;
      d_w1_data = 16'h0000;
      d_fmask = 5'h00;
      d_fval = 5'h00;
      d_bitor = 1'b0;
      d_bitval = 1'b0;
      // a port being modified is read from its output latch
      dest_b = (dir_is_port && (op_byte0 == `OP_OR_D_A ||
                op_byte0 == `OP_OR_D_I)) ?
               latch_val : opnd_a[7:0];
      or_b = dest_b | opnd_b[7:0];
      or_w = opnd_a | opnd_b;
      case (op_byte0)
         `OP_NOP:
         begin
            // nothing written, completion only moves the pc
            d_states = `ST_ONE;
         end
         `OP_ZEXT:
         begin
            d_form = FORM_EXT;
            d_states = `ST_ONE;
            d_len = 3'd2;
            d_w0_en = 1'b1;
            d_w0_idx = {op_byte1[7:4], 1'b0};
            d_w0_word = 1'b1;
            d_w0_data = {8'h00, opnd_b[7:0]};
         end
         `OP_MUL_B:
         begin
            d_form = FORM_EXT;
            d_states = `ST_MUL_B;
            d_len = 3'd2;
            // even index gets the low byte, odd the high byte
            d_w0_en = 1'b1;
            d_w0_idx = {1'b0, op_byte1[7:5], 1'b0};
            d_w0_data = {8'h00, prod8[7:0]};
            d_w1_en = 1'b1;
            d_w1_idx = {1'b0, op_byte1[7:5], 1'b1};
            d_w1_data = {8'h00, prod8[15:8]};
            d_fmask = 5'h17;
            d_fval[`FLG_CY] = 1'b0;
            d_fval[`FLG_OV] = (prod8[15:8] != 8'h00);
            d_fval[`FLG_N] = prod8[15];
            d_fval[`FLG_Z] = (prod8 == 16'h0000);
         end
         `OP_MUL_W:
         begin
            d_form = FORM_EXT;
            d_states = `ST_MUL_W;
            d_len = 3'd2;
            d_w0_en = 1'b1;
            d_w0_idx = {op_byte1[7:5], 2'b00};
            d_w0_word = 1'b1;
            d_w0_data = prod16[15:0];
            d_w1_en = 1'b1;
            d_w1_idx = {op_byte1[7:5], 2'b10};
            d_w1_word = 1'b1;
            d_w1_data = prod16[31:16];
            d_fmask = 5'h17;
            d_fval[`FLG_CY] = 1'b0;
            d_fval[`FLG_OV] = (prod16[31:16] != 16'h0000);
            d_fval[`FLG_N] = prod16[31];
            d_fval[`FLG_Z] = (prod16 == 32'h00000000);
         end
         `OP_MUL_AB:
         begin
            d_states = `ST_MUL_AB;
            d_w0_en = 1'b1;
            d_w0_kind = `KIND_ACC;
            d_w0_data = {8'h00, prod8[7:0]};
            d_w1_en = 1'b1;
            d_w1_kind = `KIND_B;
            d_w1_data = {8'h00, prod8[15:8]};
            d_fmask = 5'h17;
            d_fval[`FLG_CY] = 1'b0;
            d_fval[`FLG_OV] = (prod8[15:8] != 8'h00);
            d_fval[`FLG_N] = prod8[15];
            d_fval[`FLG_Z] = (prod8 == 16'h0000);
         end
         `OP_OR_D_A, `OP_OR_D_I:
         begin
            // direct destination, source accumulator or immediate
            d_len = (op_byte0 == `OP_OR_D_A) ? 3'd2 : 3'd3;
            if (op_byte0 == `OP_OR_D_A)
               d_states = `ST_TWO + (dir_is_port ?
                          `ST_PORT_OR_D_A : 4'd0);
            else
               d_states = `ST_THREE + (dir_is_port ?
                          `ST_PORT_ONE : 4'd0);
            d_w0_en = 1'b1;
            d_w0_kind = `KIND_DIR;
            d_w0_data = {8'h00, or_b};
         end
         `OP_OR_A_I, `OP_OR_A_D, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A,
         8'h4B:
         begin
            // accumulator destination forms
            d_len = 3'd1;
            d_states = `ST_ONE;
            if (op_byte0 == `OP_OR_A_I)
               d_len = 3'd2;
            else if (op_byte0 == `OP_OR_A_D)
            begin
               d_len = 3'd2;
               d_states = `ST_ONE + (dir_is_port ?
                          `ST_PORT_ONE : 4'd0);
            end
            else if (op_byte0[3] == 1'b0)
            begin
               // register-indirect source
               d_form = FORM_ORIG;
               d_states = `ST_TWO;
            end
            else
               d_form = FORM_ORIG; // plain register source
            d_w0_en = 1'b1;
            d_w0_kind = `KIND_ACC;
            d_w0_data = {8'h00, or_b};
         end
         8'h4F:
         begin
            // last plain register source, same as the group above
            d_form = FORM_ORIG;
            d_w0_en = 1'b1;
            d_w0_kind = `KIND_ACC;
            d_w0_data = {8'h00, or_b};
         end
         `OP_OR_RR:
         begin
            d_form = FORM_EXT;
            d_states = `ST_ONE;
            d_len = 3'd2;
            d_w0_en = 1'b1;
            d_w0_idx = {1'b0, op_byte1[7:4]};
            d_w0_data = {8'h00, or_b};
         end
         `OP_OR_WW:
         begin
            d_form = FORM_EXT;
            d_states = `ST_TWO;
            d_len = 3'd2;
            d_w0_en = 1'b1;
            d_w0_idx = {op_byte1[7:4], 1'b0};
            d_w0_word = 1'b1;
            d_w0_data = or_w;
         end
         `OP_OR_EXT:
         begin
            d_form = FORM_EXT;
            d_w0_en = 1'b1;
            d_w0_idx = {1'b0, op_byte1[7:4]};
            d_w0_data = {8'h00, or_b};
            case (op_byte1[3:0])
               4'h0:
               begin
                  d_states = `ST_TWO;
                  d_len = 3'd3;
               end
               4'h4:
               begin
                  d_states = `ST_THREE;
                  d_len = 3'd4;
                  d_w0_idx = {op_byte1[7:4], 1'b0};
                  d_w0_word = 1'b1;
                  d_w0_data = or_w;
               end
               4'h1:
               begin
                  d_states = `ST_TWO + (dir_is_port ?
                             `ST_PORT_ONE : 4'd0);
                  d_len = 3'd3;
               end
               4'h5:
               begin
                  d_states = `ST_THREE;
                  d_len = 3'd3;
                  d_w0_idx = {op_byte1[7:4], 1'b0};
                  d_w0_word = 1'b1;
                  d_w0_data = or_w;
               end
               4'h3:
               begin
                  d_states = `ST_TWO;
                  d_len = 3'd4;
               end
               4'h7:
               begin
                  d_states = `ST_THREE;
                  d_len = 3'd4;
                  d_w0_idx = {op_byte1[7:4], 1'b0};
                  d_w0_word = 1'b1;
                  d_w0_data = or_w;
               end
               4'h9, 4'hB:
               begin
                  // indirect: destination byte register in third byte
                  d_states = (op_byte1[1]) ? `ST_THREE : `ST_TWO;
                  d_len = 3'd3;
                  d_w0_idx = {1'b0, op_byte2[7:4]};
               end
               default:
               begin
                  d_ok = 1'b0;
                  d_w0_en = 1'b0;
               end
            endcase
         end
         `OP_ORC_B, `OP_ORC_NB:
         begin
            d_len = 3'd2;
            d_states = `ST_ONE + (dir_is_port ? `ST_PORT_ONE : 4'd0);
            d_bitor = 1'b1;
            // complement form inverts only the value used
            d_bitval = (op_byte0 == `OP_ORC_NB) ? ~src_bit :
                       src_bit;
         end
         `OP_ORC_EXT:
         begin
            d_form = FORM_EXT;
            d_len = 3'd3;
            d_states = `ST_TWO + (dir_is_port ? `ST_PORT_ONE : 4'd0);
            d_bitor = 1'b1;
            if (op_byte1[7:3] == 5'b01110)
               d_bitval = src_bit;
            else if (op_byte1[7:3] == 5'b11100)
               d_bitval = ~src_bit;
            else
            begin
               d_ok = 1'b0;
               d_bitor = 1'b0;
            end
         end
         default:
            d_ok = 1'b0;
      endcase
      // unescaped in binary mode or escaped in source mode, 4C-4E are plain register sources
      if ((op_byte0 == `OP_OR_RR || op_byte0 == `OP_OR_WW ||
           op_byte0 == `OP_OR_EXT) && (esc_seen == src_mode))
      begin
         d_form = FORM_ORIG;
         d_ok = 1'b1;
         d_states = `ST_ONE;
         d_len = 3'd1;
         d_w0_en = 1'b1;
         d_w0_kind = `KIND_ACC;
         d_w0_idx = 5'h00;
         d_w0_word = 1'b0;
         d_w0_data = {8'h00, or_b};
         d_bitor = 1'b0;
      end
      // or results touch only negative and zero
      if (d_w0_en && (op_byte0[7:4] == 4'h4))
      begin
         d_fmask = 5'h03;
         d_fval[`FLG_N] = d_w0_word ? d_w0_data[15] :
                          d_w0_data[7];
         d_fval[`FLG_Z] = (d_w0_data == 16'h0000);
      end
   end

   // state period counter and completion
   always @(posedge clk)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         cnt_r <= 4'd0;
      end
      else if (take)
      begin
         busy_r <= 1'b1;
         // an unknown code retires after one period
         cnt_r <= (d_ok && esc_ok) ? total - 4'd1 : 4'd0;
      end
      else if (last)
         busy_r <= 1'b0;
      else if (busy_r)
         cnt_r <= cnt_r - 4'd1;
   end

   // capture results at issue; outputs may still show the previous ones
   always @(posedge clk)
   begin
      if (rst)
      begin
         p_illegal_r <= 1'b0;
         p_len_r <= 3'd0;
         p_w0_en_r <= 1'b0;
         p_w0_kind_r <= `KIND_REG;
         p_w0_idx_r <= 5'h00;
         p_w0_word_r <= 1'b0;
         p_w0_data_r <= 16'h0000;
         p_w1_en_r <= 1'b0;
         p_w1_kind_r <= `KIND_REG;
         p_w1_idx_r <= 5'h00;
         p_w1_word_r <= 1'b0;
         p_w1_data_r <= 16'h0000;
         p_fmask_r <= 5'h00;
         p_fval_r <= 5'h00;
         p_bitor_r <= 1'b0;
         p_bitval_r <= 1'b0;
      end
      else if (take)
      begin
         p_illegal_r <= ~(d_ok && esc_ok);
         p_len_r <= d_len + {2'b00, esc_add};
         p_w0_en_r <= d_w0_en & d_ok & esc_ok;
         p_w0_kind_r <= d_w0_kind;
         p_w0_idx_r <= d_w0_idx;
         p_w0_word_r <= d_w0_word;
         p_w0_data_r <= d_w0_data;
         p_w1_en_r <= d_w1_en & d_ok & esc_ok;
         p_w1_kind_r <= d_w1_kind;
         p_w1_idx_r <= d_w1_idx;
         p_w1_word_r <= d_w1_word;
         p_w1_data_r <= d_w1_data;
         p_fmask_r <= (d_ok && esc_ok) ? d_fmask : 5'h00;
         p_fval_r <= d_fval;
         p_bitor_r <= d_bitor & d_ok & esc_ok;
         p_bitval_r <= d_bitval;
      end
   end

   // completion outputs: one-cycle strobes, data held until the next
   always @(posedge clk)
   begin
      if (rst)
      begin
         done_r <= 1'b0;
         illegal_pulse_r <= 1'b0;
         len_r <= 3'd0;
         wr0_en_r <= 1'b0;
         wr0_kind_r <= `KIND_REG;
         wr0_idx_r <= 5'h00;
         wr0_word_r <= 1'b0;
         wr0_data_r <= 16'h0000;
         wr1_en_r <= 1'b0;
         wr1_kind_r <= `KIND_REG;
         wr1_idx_r <= 5'h00;
         wr1_word_r <= 1'b0;
         wr1_data_r <= 16'h0000;
      end
      else
      begin
         done_r <= last;
         illegal_pulse_r <= last & p_illegal_r;
         wr0_en_r <= last & p_w0_en_r;
         wr1_en_r <= last & p_w1_en_r;
         if (last)
         begin
            len_r <= p_len_r;
            wr0_kind_r <= p_w0_kind_r;
            wr0_idx_r <= p_w0_idx_r;
            wr0_word_r <= p_w0_word_r;
            wr0_data_r <= p_w0_data_r;
            wr1_kind_r <= p_w1_kind_r;
            wr1_idx_r <= p_w1_idx_r;
            wr1_word_r <= p_w1_word_r;
            wr1_data_r <= p_w1_data_r;
         end
      end
   end

   // flags: completion beats a software write in the same cycle
   always @(posedge clk)
   begin
      if (rst)
         flags_r <= `FLAGS_RST;
      else if (last)
      begin
         flags_r <= (flags_r & ~p_fmask_r) | (p_fval_r & p_fmask_r);
         if (p_bitor_r)
            flags_r[`FLG_CY] <= flags_r[`FLG_CY] | p_bitval_r;
      end
      else if (reg_wr && reg_addr == `REG_FLAGS)
         flags_r <= reg_wdata[4:0];
   end

   // sticky illegal bit, write one to clear; a new event wins
   always @(posedge clk)
   begin
      if (rst)
         illegal_r <= 1'b0;
      else if (last && p_illegal_r)
         illegal_r <= 1'b1;
      else if (reg_wr && reg_addr == `REG_STATUS &&
               reg_wdata[`STS_ILLEGAL])
         illegal_r <= 1'b0;
   end

   // register read, data valid the cycle after the strobe
   always @(posedge clk)
   begin
      if (rst)
         reg_rdata_r <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `REG_FLAGS: reg_rdata_r <= {3'b000, flags_r};
            `REG_STATUS: reg_rdata_r <= {6'b000000, illegal_r, busy_r};
            default: reg_rdata_r <= 8'h00; // unmapped reads zero
         endcase
      end
      else
         reg_rdata_r <= 8'h00;
   end

endmodule

// ===== sim/or_mul_alu_props.sv
// concurrent checks on the execution slice ports
module or_mul_alu_props (
   input wire clk,
   input wire rst,
   input wire issue,
   input wire ready,
   input wire src_mode,
   input wire esc_seen,
   input wire [7:0] op_byte0,
   input wire done_r,
   input wire illegal_pulse_r,
   input wire [2:0] len_r,
   input wire wr0_en_r,
   input wire [4:0] wr0_idx_r,
   input wire wr0_word_r,
   input wire [15:0] wr0_data_r,
   input wire wr1_en_r,
   input wire [1:0] wr1_kind_r,
   input wire [4:0] wr1_idx_r,
   input wire wr1_word_r,
   input wire [4:0] flags
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // instruction accepted on this edge
   wire take = issue & ready;
   property p_nop;
      take && op_byte0 == 8'h00 |-> ##2 done_r && !wr0_en_r && len_r == 3'h1;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op wrong");
   property p_zext;
      take && op_byte0 == 8'h0A && src_mode && !esc_seen
         |-> ##2 done_r && wr0_word_r && wr0_data_r[15:8] == 8'h00;
   endproperty
   a_zext: assert property (p_zext) else $error("zext wrong");
   property p_mulb;
      take && op_byte0 == 8'hAC && esc_seen && !src_mode
         |-> ##7 done_r && wr0_en_r && wr1_en_r;
   endproperty
   a_mulb: assert property (p_mulb) else $error("mul byte late");
   // ready must stay low for the first eight cycles after the long multiply is taken
   property p_mulw;
      take && op_byte0 == 8'hAD && src_mode && !esc_seen
         |=> !ready [*8] ##4 done_r;
   endproperty
   a_mulw: assert property (p_mulw) else $error("mul word time");
   property p_mulab;
      take && op_byte0 == 8'hA4
         |-> ##1 !done_r [*5] ##1 done_r && wr1_kind_r == 2'h2;
   endproperty
   a_mulab: assert property (p_mulab) else $error("mul ab wrong");
   property p_carry;
      wr0_en_r && wr1_en_r |-> flags[4] == 1'b0;
   endproperty
   a_carry: assert property (p_carry) else $error("mul kept carry");
   property p_pair;
      wr0_en_r && wr1_en_r && wr1_kind_r == 2'h0 |-> !wr0_idx_r[0]
         && wr1_idx_r == wr0_idx_r + (wr1_word_r ? 5'h2 : 5'h1);
   endproperty
   a_pair: assert property (p_pair) else $error("pair index");
   property p_orkeep;
      take && op_byte0 == 8'h44
         |-> ##2 done_r && flags[4:2] == $past(flags[4:2], 2);
   endproperty
   a_orkeep: assert property (p_orkeep) else $error("or flags");
   property p_illegal;
      illegal_pulse_r |-> done_r && !wr0_en_r && !wr1_en_r && $stable(flags);
   endproperty
   a_illegal: assert property (p_illegal) else $error("refusal");
   c_mulb: cover property (take && op_byte0 == 8'hAC);
   c_illegal: cover property (illegal_pulse_r);
   c_zext: cover property (take && op_byte0 == 8'h0A);
endmodule

bind or_mul_alu or_mul_alu_props or_mul_alu_props_i (.clk, .rst, .issue,
   .ready, .src_mode, .esc_seen, .op_byte0, .done_r, .illegal_pulse_r,
   .len_r, .wr0_en_r, .wr0_idx_r, .wr0_word_r, .wr0_data_r, .wr1_en_r,
   .wr1_kind_r, .wr1_idx_r, .wr1_word_r, .flags);

// ===== sim/multiply_or_zero_extend_alu_tb_top.sv
// self-checking bench for the execution slice
module multiply_or_zero_extend_alu_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, issue = 0, src_mode = 0, esc_seen = 0;
   logic dir_is_port = 0, src_bit = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] op_byte0 = 0, op_byte1 = 0, op_byte2 = 0, latch_val = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0;
   logic [15:0] opnd_a = 0, opnd_b = 0;
   wire ready, done_r, illegal_pulse_r, wr0_en_r, wr1_en_r;
   wire wr0_word_r, wr1_word_r;
   wire [2:0] len_r;
   wire [1:0] wr0_kind_r, wr1_kind_r;
   wire [4:0] wr0_idx_r, wr1_idx_r, flags;
   wire [15:0] wr0_data_r, wr1_data_r;
   wire [7:0] reg_rdata_r;
   int bad_count = 0, num_checks = 0;
   or_mul_alu or_mul_alu_i (.clk, .rst, .issue, .ready, .src_mode,
      .esc_seen, .op_byte0, .op_byte1, .op_byte2, .opnd_a, .opnd_b,
      .dir_is_port, .latch_val, .src_bit, .done_r, .illegal_pulse_r,
      .len_r, .wr0_en_r, .wr0_kind_r, .wr0_idx_r, .wr0_word_r,
      .wr0_data_r, .wr1_en_r, .wr1_kind_r, .wr1_idx_r, .wr1_word_r,
      .wr1_data_r, .flags, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r);
   always #50 clk = ~clk;
   // compare one value, count and report
   task chk(input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one-cycle register write
   task wr(input logic [7:0] a, d);
      @(posedge clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, exp);
      @(posedge clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 0;
      @(negedge clk);
      chk(reg_rdata_r, exp);
   endtask
   // issue from idle and count cycles until completion
   task op(input logic e, s, input logic [7:0] b0, b1,
      input logic [15:0] a, b, input int n);
      int k;
      @(posedge clk);
      issue <= 1;
      esc_seen <= e;
      src_mode <= s;
      op_byte0 <= b0;
      op_byte1 <= b1;
      op_byte2 <= 8'h20;
      opnd_a <= a;
      opnd_b <= b;
      @(posedge clk);
      issue <= 0;
      k = 1;
      @(negedge clk);
      while (done_r !== 1'b1 && k < 40)
      begin
         k++;
         @(negedge clk);
      end
      chk(k, n + 1);
   endtask
   // both halves of a multiply
   task mchk(input logic [4:0] i0, i1, input logic [15:0] lo, hi,
      input logic [4:0] f);
      chk({wr0_en_r, wr1_en_r, wr0_idx_r, wr1_idx_r}, {2'h3, i0, i1});
      chk({wr0_data_r, wr1_data_r}, {lo, hi});
      chk(flags, f);
   endtask
   task t_nop;
      wr(8'h00, 8'h1F);
      op(0, 0, 8'h00, 8'h00, 16'h0, 16'h0, 1);
      chk({wr0_en_r, wr1_en_r, len_r, flags}, 10'h03F);
   endtask
   // high byte of the source must not leak through
   task t_zext;
      op(0, 1, 8'h0A, 8'h35, 16'hFFFF, 16'hAB96, 1);
      chk({wr0_en_r, wr0_word_r, wr0_idx_r, wr0_data_r}, 23'h660096);
      op(1, 0, 8'h0A, 8'h35, 16'hFFFF, 16'h0096, 2);
      chk(len_r, 3'h3);
      op(0, 0, 8'h0A, 8'h35, 16'hFFFF, 16'h0096, 1);
      chk({illegal_pulse_r, wr0_en_r}, 2'h2);
   endtask
   // carry is preset so that clearing it shows
   task t_mul;
      wr(8'h00, 8'h10);
      op(1, 0, 8'hAC, 8'h10, 16'h50, 16'hA0, 6);
      mchk(5'd0, 5'd1, 16'h00, 16'h32, 5'h04);
      wr(8'h00, 8'h10);
      op(0, 1, 8'hAC, 8'hE0, 16'h00, 16'h07, 5);
      mchk(5'd14, 5'd15, 16'h0, 16'h0, 5'h01);
      op(0, 1, 8'hAC, 8'h32, 16'hFF, 16'h81, 5);
      mchk(5'd2, 5'd3, 16'h7F, 16'h80, 5'h06);
      wr(8'h00, 8'h10);
      op(0, 1, 8'hAD, 8'hF0, 16'hFFFF, 16'hFFFF, 11);
      mchk(5'd28, 5'd30, 16'h0001, 16'hFFFE, 5'h06);
      op(1, 0, 8'hAD, 8'h01, 16'h2, 16'h3, 12);
      mchk(5'd0, 5'd2, 16'h6, 16'h0, 5'h00);
      wr(8'h00, 8'h18);
      op(0, 0, 8'hA4, 8'h00, 16'h50, 16'hA0, 5);
      chk({wr0_kind_r, wr1_kind_r, wr0_data_r[7:0], wr1_data_r[7:0], flags},
         {2'h1, 2'h2, 8'h00, 8'h32, 5'h0C});
   endtask
   // ports being modified read the latch, never the pins
   task t_or;
      wr(8'h00, 8'h1C);
      op(0, 0, 8'h44, 8'h55, 16'hC3, 16'h55, 1);
      chk({wr0_kind_r, wr0_data_r, flags, len_r}, 26'h100D7F2);
      op(1, 0, 8'h4C, 8'h12, 16'h0, 16'h0, 2);
      chk({wr0_idx_r, wr0_data_r, flags}, 26'h20001D);
      op(0, 1, 8'h4D, 8'h12, 16'h8000, 16'h0001, 2);
      chk({wr0_word_r, wr0_data_r, flags}, 22'h30003E);
      op(0, 0, 8'h48, 8'h00, 16'h1, 16'h2, 1);
      // unescaped 4C in binary mode is the accumulator register form
      op(0, 0, 8'h4C, 8'h00, 16'h81, 16'h02, 1);
      chk({wr0_kind_r, wr0_data_r[7:0]}, 10'h183);
      op(1, 1, 8'h46, 8'h00, 16'h0, 16'h0, 3);
      op(1, 0, 8'hA9, 8'h70, 16'h0, 16'h0, 3);
      @(posedge clk);
      dir_is_port <= 1;
      latch_val <= 8'h0F;
      op(0, 0, 8'h42, 8'h90, 16'hF0, 16'h30, 4);
      chk({wr0_kind_r, wr0_data_r}, 18'h3003F);
      op(0, 0, 8'h43, 8'h90, 16'h00, 16'h01, 4);
      op(0, 0, 8'h45, 8'h90, 16'h00, 16'h01, 2);
      op(0, 1, 8'h4E, 8'h11, 16'h0, 16'h1, 3);
      @(posedge clk);
      dir_is_port <= 0;
      op(0, 0, 8'h43, 8'h90, 16'h00, 16'h01, 3);
      // source nibbles 0,4,1,5,3,7,9,B: byte forms 2 states except B at 3, word forms 3
      for (int i = 0; i < 8; i++)
         op(0, 1, 8'h4E, {4'h1, 4'(32'hB9735140 >> (4 * i))},
            16'h0, 16'h0, 2 + i % 2);
   endtask
   // plain and complemented bit into carry, other flags kept
   task t_cy;
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h00, 8'h0E);
         src_bit <= i % 2;
         op(0, 0, i > 1 ? 8'hA0 : 8'h72, 8'h00, 16'h0, 16'h0, 1);
         chk(flags, {1'((i % 2) ^ (i / 2)), 4'hE});
      end
   endtask
   // sticky refusal bit, write-one clear, unmapped read
   task t_regs;
      op(0, 0, 8'hFF, 8'h00, 16'h0, 16'h0, 1);
      rd(8'h04, 8'h02);
      wr(8'h04, 8'h02);
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h00);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 0;
      @(negedge clk);
      chk({ready, flags}, 6'h20);
      rd(8'h00, 8'h00);
      t_nop;
      t_zext;
      t_mul;
      t_or;
      t_cy;
      t_regs;
      end_sim;
   end
   // hang guard, far beyond the few hundred cycles used
   initial
   begin
      #2000000;
      bad_count++;
      end_sim;
   end
endmodule
